// File: hdl/slm_filt_if.sv
`timescale 1ns/1ns
`default_nettype none
interface slm_filt_if;
  import slm_pkg::*;
  logic                enable;
  logic [FILT_W-1:0]   reload;
  logic [BITLEN_W-1:0] bit_len;
  logic                rxd;
  logic                demod;
  modport owner (output enable, output reload, output bit_len, output rxd, input demod);
  modport filter (input enable, input reload, input bit_len, input rxd, output demod);
endinterface : slm_filt_if
`default_nettype wire

// File: hdl/slm_ir_filter.sv
`timescale 1ns/1ns
`default_nettype none
module slm_ir_filter (
  // Clocking.
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // Filter link.
  slm_filt_if.filter f
);
  import slm_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_COUNT = 3'b010,
    ST_FORCE = 3'b100
  } slm_filt_e;

  slm_filt_e           state_q;
  logic [FILT_W-1:0]   cnt_q;
  logic [BITLEN_W-1:0] force_q;
  logic                rxd_prev_q;
  logic                fall;
  logic                rise;

  assign fall = rxd_prev_q & ~f.rxd;
  assign rise = ~rxd_prev_q & f.rxd;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rxd_prev_q <= 1'b1;
    end else if (ce) begin
      rxd_prev_q <= f.rxd;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
      cnt_q   <= FILT_RESET;
      force_q <= '0;
    end else if (ce) begin
      if (!f.enable) begin
        state_q <= ST_IDLE;
        cnt_q   <= f.reload;
      end else begin
        case (state_q)
          ST_IDLE: begin
            cnt_q <= f.reload;
            if (fall) begin
              state_q <= ST_COUNT;
            end
          end
          ST_COUNT: begin
            if (rise) begin
              state_q <= ST_IDLE;
              cnt_q   <= f.reload;
            end else if (cnt_q == '0) begin
              state_q <= ST_FORCE;
              force_q <= f.bit_len;
              cnt_q   <= f.reload;
            end else begin
              cnt_q <= cnt_q - 1'b1;
            end
          end
          ST_FORCE: begin
            if (force_q <= BITLEN_W'(1)) begin
              state_q <= ST_IDLE;
            end else begin
              force_q <= force_q - 1'b1;
            end
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // The receiver sees low only while a valid pulse stretches to one bit.
  assign f.demod = (state_q != ST_FORCE);

endmodule : slm_ir_filter
`default_nettype wire

// File: hdl/slm_pkg.sv
package slm_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // Byte addresses of the registers.
  localparam logic [7:0] OFS_COMMAND = 8'h00;
  localparam logic [7:0] OFS_MODE    = 8'h04;
  localparam logic [7:0] OFS_STATUS  = 8'h14;
  localparam logic [7:0] OFS_RATIO   = 8'h40;
  localparam logic [7:0] OFS_FILTER  = 8'h4C;
  localparam logic [7:0] OFS_BITLEN  = 8'h50;

  // Command register bits.
  localparam int unsigned CMD_DTR_ON  = 16;
  localparam int unsigned CMD_DTR_OFF = 17;
  localparam int unsigned CMD_RTS_ON  = 18;
  localparam int unsigned CMD_RTS_OFF = 19;

  // Mode register fields.
  localparam int unsigned MODE_LSB   = 0;
  localparam int unsigned MODE_W     = 4;
  localparam int unsigned CHANNEL_MODE_FIELD_LSB = 14;
  localparam int unsigned CHANNEL_MODE_FIELD_W   = 2;

  // Status register fields: four change flags, then four live levels.
  localparam int unsigned STAT_FLAG_LSB  = 16;
  localparam int unsigned STAT_LEVEL_LSB = 20;

  localparam int unsigned RATIO_W     = 11;
  localparam int unsigned FILT_W      = 8;
  localparam int unsigned BITLEN_W    = 16;
  localparam logic [10:0] RATIO_RESET = 11'h174;
  localparam logic [7:0]  FILT_RESET  = 8'h00;
  localparam logic [15:0] BITLEN_RESET = 16'h0010;

  localparam logic [3:0] MODE_NORMAL    = 4'h0;
  localparam logic [3:0] MODE_LINE_DRV  = 4'h1;
  localparam logic [3:0] MODE_HANDSHAKE = 4'h2;
  localparam logic [3:0] MODE_MODEM     = 4'h3;
  localparam logic [3:0] MODE_INFRARED  = 4'h8;

  typedef enum logic [1:0] {
    CH_NORMAL = 2'h0,
    CH_ECHO   = 2'h1,
    CH_LOCAL  = 2'h2,
    CH_REMOTE = 2'h3
  } slm_channel_mode_field_e;

  // Modem input order inside the flag and level fields.
  localparam int unsigned IN_RI  = 0;
  localparam int unsigned IN_DSR = 1;
  localparam int unsigned IN_DCD = 2;
  localparam int unsigned IN_CTS = 3;
  localparam int unsigned N_IN   = 4;

endpackage : slm_pkg

// File: hdl/slm_top.sv
// Overview of operation
// - Infrared filter uses 8-bit reloadable down counter.
// - Receive falling edge starts per-clock countdown.
// - Rising edge stops counter and reloads it.
// - Count reaching zero forces receiver low one bit.
// - Mode value 0x1 selects line-driver mode.
// - Line-driver RTS pin follows transmitter empty level.
// - Line-driver RTS stays low through timeguard.
// - Mode value 0x3 selects modem mode.
// - Modem mode drives DTR, RTS, watches inputs.
// - Disable commands drive high, enable commands low.
// - Modem input changes set individual status flags.
// - Reading channel status clears change flags.
// - Inactive CTS disables transmitter after current character.
// - Normal: pin to receiver, transmitter to pin.
// - Echo: receive pin copied to transmit pin.
// - Local loopback: transmitter feeds receiver, pin high.
// - Remote loopback: pins joined, transmitter, receiver off.
// - Mode value 0x8 selects infrared demodulation.
// - Channel mode field encodes normal mode and three test modes.
//
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module slm_top (
  // Clocking.
  input  wire logic                       clk,
  input  wire logic                       nrst,
  input  wire logic                       ce,
  // Register port.
  input  wire logic [slm_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [slm_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [slm_pkg::DATA_W-1:0] reg_rdata,
  // Core transceiver side.
  input  wire logic                       core_txd,
  input  wire logic                       core_tx_empty,
  input  wire logic                       core_tx_busy,
  output logic                            core_rxd,
  output logic                            core_tx_allow,
  output logic                            core_rx_allow,
  // Line pins.
  input  wire logic                       rxd_pin,
  output logic                            txd_pin,
  output logic                            rts_n,
  output logic                            dtr_n,
  input  wire logic                       dsr_n,
  input  wire logic                       dcd_n,
  input  wire logic                       cts_n,
  input  wire logic                       ri_n
);
  import slm_pkg::*;

  logic [MODE_W-1:0]   mode_q;
  slm_channel_mode_field_e         channel_mode_field_q;
  logic [RATIO_W-1:0]  ratio_q;
  logic [FILT_W-1:0]   filt_q;
  logic [BITLEN_W-1:0] bitlen_q;
  logic                rts_cmd_q;
  logic                dtr_cmd_q;
  logic [N_IN-1:0]     sync1_q;
  logic [N_IN-1:0]     sync2_q;
  logic [N_IN-1:0]     last_q;
  logic [N_IN-1:0]     flag_q;
  logic [N_IN-1:0]     change;
  logic                stat_rd;
  logic                rx_src;
  logic                hs_mode;

  slm_filt_if filt ();

  assign filt.enable  = (mode_q == MODE_INFRARED);
  assign filt.reload  = filt_q;
  assign filt.bit_len = bitlen_q;
  assign filt.rxd     = rxd_pin;

  slm_ir_filter u_filter (
    .clk  (clk),
    .nrst (nrst),
    .ce   (ce),
    .f    (filt.filter)
  );

  // Configuration registers.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode_q   <= MODE_NORMAL;
      channel_mode_field_q <= CH_NORMAL;
      ratio_q  <= RATIO_RESET;
      filt_q   <= FILT_RESET;
      bitlen_q <= BITLEN_RESET;
    end else if (ce && reg_wr) begin
      case (reg_addr)
        OFS_MODE: begin
          mode_q   <= reg_wdata[MODE_LSB +: MODE_W];
          channel_mode_field_q <= slm_channel_mode_field_e'(reg_wdata[CHANNEL_MODE_FIELD_LSB +: CHANNEL_MODE_FIELD_W]);
        end
        OFS_RATIO: begin
          ratio_q <= reg_wdata[RATIO_W-1:0];
        end
        OFS_FILTER: begin
          filt_q <= reg_wdata[FILT_W-1:0];
        end
        OFS_BITLEN: begin
          bitlen_q <= reg_wdata[BITLEN_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Command bits; when both of a pair are set the disable wins, leaving the line inactive.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rts_cmd_q <= 1'b1;
      dtr_cmd_q <= 1'b1;
    end else if (ce && reg_wr && reg_addr == OFS_COMMAND) begin
      if (reg_wdata[CMD_RTS_OFF]) begin
        rts_cmd_q <= 1'b1;
      end else if (reg_wdata[CMD_RTS_ON]) begin
        rts_cmd_q <= 1'b0;
      end
      if (reg_wdata[CMD_DTR_OFF]) begin
        dtr_cmd_q <= 1'b1;
      end else if (reg_wdata[CMD_DTR_ON]) begin
        dtr_cmd_q <= 1'b0;
      end
    end
  end

  // Two-stage synchronizer, then a third stage held for change detection.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1_q <= '1;
      sync2_q <= '1;
      last_q  <= '1;
    end else if (ce) begin
      sync1_q <= {cts_n, dcd_n, dsr_n, ri_n};
      sync2_q <= sync1_q;
      last_q  <= sync2_q;
    end
  end

  assign change  = sync2_q ^ last_q;
  assign stat_rd = reg_rd && (reg_addr == OFS_STATUS);

  // A change arriving with the clearing read is kept.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flag_q <= '0;
    end else if (ce) begin
      flag_q <= (stat_rd ? '0 : flag_q) | change;
    end
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= '0;
    end else if (ce) begin
      reg_rdata <= '0;
      if (reg_rd) begin
        case (reg_addr)
          OFS_MODE: begin
            reg_rdata[MODE_LSB +: MODE_W]     <= mode_q;
            reg_rdata[CHANNEL_MODE_FIELD_LSB +: CHANNEL_MODE_FIELD_W] <= channel_mode_field_q;
          end
          OFS_STATUS: begin
            reg_rdata[STAT_FLAG_LSB +: N_IN]  <= flag_q;
            reg_rdata[STAT_LEVEL_LSB +: N_IN] <= sync2_q;
          end
          OFS_RATIO: begin
            reg_rdata[RATIO_W-1:0] <= ratio_q;
          end
          OFS_FILTER: begin
            reg_rdata[FILT_W-1:0] <= filt_q;
          end
          OFS_BITLEN: begin
            reg_rdata[BITLEN_W-1:0] <= bitlen_q;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Modem outputs; the transmitter-empty input already spans the timeguard.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rts_n <= 1'b1;
      dtr_n <= 1'b1;
    end else if (ce) begin
      dtr_n <= dtr_cmd_q;
      if (mode_q == MODE_LINE_DRV) begin
        rts_n <= core_tx_empty;
      end else begin
        rts_n <= rts_cmd_q;
      end
    end
  end

  assign hs_mode = (mode_q == MODE_MODEM) || (mode_q == MODE_HANDSHAKE);

  // Transmit permission; on inactive CTS a character in flight finishes before it drops, remote loopback drops it at once.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      core_tx_allow <= 1'b1;
    end else if (ce) begin
      if (channel_mode_field_q == CH_REMOTE) begin
        core_tx_allow <= 1'b0;
      end else if (!hs_mode || !sync2_q[IN_CTS]) begin
        core_tx_allow <= 1'b1;
      end else if (!core_tx_busy) begin
        core_tx_allow <= 1'b0;
      end
    end
  end

  always_comb begin
    if (channel_mode_field_q == CH_LOCAL) begin
      rx_src = core_txd;
    end else if (mode_q == MODE_INFRARED) begin
      rx_src = filt.demod;
    end else begin
      rx_src = rxd_pin;
    end
  end

  // Pin routing follows the channel mode one clock after it is written.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      txd_pin       <= 1'b1;
      core_rxd      <= 1'b1;
      core_rx_allow <= 1'b1;
    end else if (ce) begin
      core_rxd      <= rx_src;
      core_rx_allow <= (channel_mode_field_q != CH_REMOTE);
      case (channel_mode_field_q)
        CH_NORMAL: txd_pin <= core_txd;
        CH_ECHO:   txd_pin <= rxd_pin;
        CH_LOCAL:  txd_pin <= 1'b1;
        CH_REMOTE: txd_pin <= rxd_pin;
        default:   txd_pin <= 1'b1;
      endcase
    end
  end

endmodule : slm_top
`default_nettype wire

// File: testbench/serial_line_mode_extensions_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module serial_line_mode_extensions_tb_top;
  import slm_pkg::*;
  logic              clk, nrst, ce, reg_wr, reg_rd, core_txd, core_tx_empty, core_tx_busy;
  logic              core_rxd, core_tx_allow, core_rx_allow, rxd_pin, txd_pin, rts_n, dtr_n;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, d;
  logic [3:0]        mdm_n;
  logic [1:0]        e;
  int                mismatches, cmp_count, cyc_cnt, low_cnt, c0;

  slm_top dut_u (.clk, .nrst, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .core_txd,
    .core_tx_empty, .core_tx_busy, .core_rxd, .core_tx_allow, .core_rx_allow, .rxd_pin, .txd_pin,
    .rts_n, .dtr_n, .dsr_n(mdm_n[IN_DSR]), .dcd_n(mdm_n[IN_DCD]), .cts_n(mdm_n[IN_CTS]),
    .ri_n(mdm_n[IN_RI]));
  slm_line_model pm_u (.clk, .rxd_pin, .mdm_n);

  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  // Counted on the falling edge so the registered output has settled.
  always @(negedge clk) if (core_rxd === 1'h0) low_cnt++;

  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 4000) begin
      mismatches++;
      summarize();
    end
  end

  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic wr(logic [7:0] a, logic [31:0] v);
    @(posedge clk);
    reg_wr    <= 1'h1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask : wr

  task automatic rd(logic [7:0] a);
    @(posedge clk);
    reg_rd   <= 1'h1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1 d = reg_rdata;
  endtask : rd

  task automatic chk(logic [31:0] got, logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic summarize();
    $display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize

  initial begin
    {nrst, reg_wr, reg_rd, core_tx_busy} = 4'h0;
    {ce, core_txd, core_tx_empty} = 3'h7;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    repeat (8) @(posedge clk);
    nrst <= 1'h1;
    cyc(1);
    chk(32'({dtr_n, rts_n, txd_pin}), 32'h7);
    rd(OFS_RATIO); chk(d, 32'h174);
    rd(OFS_FILTER); chk(d, 32'h0);
    rd(OFS_BITLEN); chk(d, 32'h10);
    rd(8'h08); chk(d, 32'h0);
    wr(OFS_MODE, 32'h3);
    e = 2'h3;
    for (int i = CMD_DTR_ON; i <= CMD_RTS_OFF; i++) begin
      wr(OFS_COMMAND, 32'h1 << i);
      e[i < CMD_RTS_ON] = i[0];
      cyc(2);
      chk(32'({dtr_n, rts_n}), 32'(e));
    end
    for (int j = 0; j < N_IN; j++) begin
      pm_u.toggle(j);
      cyc(5);
      rd(OFS_STATUS); chk((d >> 16) & 32'hF, 32'h1 << j);
      chk((d >> 20) & 32'hF, 32'(mdm_n));
      rd(OFS_STATUS); chk((d >> 16) & 32'hF, 32'h0);
    end
    @(posedge clk) core_tx_busy <= 1'h1;
    pm_u.toggle(IN_CTS);
    cyc(6); chk(32'(core_tx_allow), 32'h1);
    @(posedge clk) core_tx_busy <= 1'h0;
    cyc(2); chk(32'(core_tx_allow), 32'h0);
    wr(OFS_MODE, 32'h1);
    // The driver enable pin is low while the transmitter is busy, i.e. not empty.
    for (int k = 0; k < 2; k++) begin
      @(posedge clk) core_tx_empty <= k[0];
      cyc(2); chk(32'(rts_n), 32'(k[0]));
    end
    cyc(1); chk(32'(core_tx_allow), 32'h1);
    // Handshake mode gates the transmitter on the inactive clear-to-send input as well.
    wr(OFS_MODE, 32'h2);
    cyc(2); chk(32'(core_tx_allow), 32'h0);
    for (int ch = 0; ch < 4; ch++) begin
      wr(OFS_MODE, 32'(ch) << CHANNEL_MODE_FIELD_LSB);
      for (int p = 0; p < 2; p++) begin
        pm_u.set_rx(p[0]);
        core_txd <= !p[0];
        cyc(3);
        chk(32'(txd_pin), 32'(ch == 0 ? !p[0] : ch == 2 ? 1'h1 : p[0]));
        chk(32'(ch == 3 ? core_rx_allow : core_rxd), 32'(ch == 2 ? !p[0] : ch != 3 && p[0]));
      end
    end
    @(posedge clk) core_txd <= 1'h1;
    wr(OFS_FILTER, 32'h8);
    wr(OFS_MODE, 32'h8);
    c0 = low_cnt;
    pm_u.pulse(3);
    cyc(30); chk(low_cnt - c0, 32'h0);
    pm_u.pulse(14);
    cyc(40); chk(low_cnt - c0, 32'h10);
    summarize();
  end
endmodule : serial_line_mode_extensions_tb_top
`default_nettype wire

// File: testbench/slm_line_model.sv
`timescale 1ns/1ns
`default_nettype none
module slm_line_model (
  // Clocking.
  input  wire logic       clk,
  // Line side.
  output logic            rxd_pin,
  output logic      [3:0] mdm_n
);
  initial begin
    rxd_pin = 1'h1;
    mdm_n   = 4'hF;
  end

  task automatic toggle(int i);
    @(posedge clk);
    mdm_n[i] <= ~mdm_n[i];
  endtask : toggle

  task automatic set_rx(logic v);
    @(posedge clk);
    rxd_pin <= v;
  endtask : set_rx

  // Pulses are whole clocks, so the far end adds no baud error of its own.
  task automatic pulse(int n);
    @(posedge clk);
    rxd_pin <= 1'h0;
    repeat (n) @(posedge clk);
    rxd_pin <= 1'h1;
  endtask : pulse
endmodule : slm_line_model
`default_nettype wire

// File: testbench/slm_top_properties.sv
`timescale 1ns/1ns
`default_nettype none
module slm_checker (
  // Clocking.
  input wire logic                       clk,
  input wire logic                       nrst,
  // Register port.
  input wire logic [slm_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [slm_pkg::DATA_W-1:0] reg_wdata,
  input wire logic                       reg_wr,
  // Core and pins.
  input wire logic                       core_txd,
  input wire logic                       core_tx_empty,
  input wire logic                       core_tx_busy,
  input wire logic                       core_rxd,
  input wire logic                       core_tx_allow,
  input wire logic                       core_rx_allow,
  input wire logic                       rxd_pin,
  input wire logic                       txd_pin,
  input wire logic                       rts_n,
  input wire logic                       dtr_n,
  input wire logic                       cts_n
);
  import slm_pkg::*;
  logic [3:0] mode_q;
  logic [1:0] ch_q;
  logic       cmd;
  logic       plain;

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  // Shadow of the mode register, updated on the same edge as the design's.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode_q <= 4'h0;
      ch_q   <= 2'h0;
    end else if (reg_wr && reg_addr == OFS_MODE) begin
      mode_q <= reg_wdata[3:0];
      ch_q   <= reg_wdata[15:14];
    end
  end

  assign cmd   = reg_wr && reg_addr == OFS_COMMAND && mode_q == MODE_MODEM;
  assign plain = mode_q == MODE_NORMAL;

  // The command lands in a register first and reaches the pin one clock later.
  property p_rts_on;
    cmd && reg_wdata[CMD_RTS_ON] && !reg_wdata[CMD_RTS_OFF] |-> ##2 !rts_n;
  endproperty
  a_rts_on: assert property (p_rts_on) else $error("rts not driven low");
  property p_rts_off;
    cmd && reg_wdata[CMD_RTS_OFF] |-> ##2 rts_n;
  endproperty
  a_rts_off: assert property (p_rts_off) else $error("rts not driven high");
  property p_dtr_on;
    cmd && reg_wdata[CMD_DTR_ON] && !reg_wdata[CMD_DTR_OFF] |-> ##2 !dtr_n;
  endproperty
  a_dtr_on: assert property (p_dtr_on) else $error("dtr not driven low");
  // The pin is low while the transmitter is busy, so it tracks the empty flag level.
  property p_line_drv;
    mode_q == MODE_LINE_DRV |=> rts_n == $past(core_tx_empty);
  endproperty
  a_line_drv: assert property (p_line_drv) else $error("rts does not follow empty");
  property p_normal;
    plain && ch_q == CH_NORMAL |=> txd_pin == $past(core_txd) && core_rxd == $past(rxd_pin);
  endproperty
  a_normal: assert property (p_normal) else $error("normal routing wrong");
  property p_echo;
    plain && ch_q == CH_ECHO |=> txd_pin == $past(rxd_pin) && core_rxd == $past(rxd_pin);
  endproperty
  a_echo: assert property (p_echo) else $error("echo routing wrong");
  property p_local;
    plain && ch_q == CH_LOCAL |=> txd_pin && core_rxd == $past(core_txd);
  endproperty
  a_local: assert property (p_local) else $error("local loop routing wrong");
  property p_remote;
    plain && ch_q == CH_REMOTE |=> txd_pin == $past(rxd_pin) && !core_rx_allow;
  endproperty
  a_remote: assert property (p_remote) else $error("remote loop routing wrong");
  property p_cts;
    (mode_q == MODE_MODEM && cts_n && !core_tx_busy) [*4] |=> !core_tx_allow;
  endproperty
  a_cts: assert property (p_cts) else $error("transmitter not stopped");
endmodule : slm_checker
bind slm_top slm_checker chk_u (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .core_txd, .core_tx_empty,
  .core_tx_busy, .core_rxd, .core_tx_allow, .core_rx_allow, .rxd_pin, .txd_pin, .rts_n, .dtr_n, .cts_n);
`default_nettype wire
